//--- pkg/scc_params.svh
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// Configuration byte offsets of the registers held by this block.
`define SCC_OFF_CLASS 8'h08
`define SCC_OFF_TIMING 8'h0c
`define SCC_OFF_LAYOUT 8'h0e
`define SCC_OFF_BASE 8'h10
`define SCC_OFF_BOARD 8'h2c
`define SCC_OFF_SUBSYS_ACCESS 8'h50
// Fixed identification fields of the class register.
`define SCC_CATEGORY 8'h07
`define SCC_SUBCLASS 8'h80
`define SCC_PGM_IF 8'h00
// Self-test and standard header layout values.
`define SCC_SELF_TEST 8'h00
`define SCC_LAYOUT_STD 7'h00
// Base address field position and width.
`define SCC_BASE_LSB 13
`define SCC_BASE_W 19
// Reset values.
`define SCC_TIMING_RESET 8'h00
`define SCC_BASE_RESET 19'h00000
`define SCC_BOARD_RESET 16'h0000
// Bus commands that use the line length.
`define SCC_CMD_READ_MULT 4'hc
`define SCC_CMD_READ_LINE 4'he
`define SCC_CMD_WRITE_INV 4'hf
// Largest tenure count; the counter saturates here.
`define SCC_TENURE_MAX 8'hff
`endif

//--- pkg/scc_pkg.sv
package scc_pkg;
  // One configuration byte.
  typedef logic [7:0] scc_byte_t;
  // One configuration dword.
  typedef logic [31:0] scc_word_t;
  // Dword selected by a configuration access, one-hot, or all zero for none.
  typedef enum logic [5:0] {
    SCC_SEL_NONE = 6'h00,
    SCC_SEL_CLASS = 6'h01,
    SCC_SEL_TIMING = 6'h02,
    SCC_SEL_BASE = 6'h04,
    SCC_SEL_BOARD = 6'h08,
    SCC_SEL_ACCESS = 6'h10
  } scc_sel_t;
endpackage

//--- verilog/scc_tenure_counter.sv
`timescale 1ns/1ps
`include "scc_params.svh"
// Counts bus-clock cycles of the block's own initiated tenure.
module scc_tenure_counter (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic frame_start,
  input wire logic active,
  input wire logic gnt_n,
  input wire scc_pkg::scc_byte_t limit,
  output logic expired,
  output logic stop_req
);
  import scc_pkg::*;

  scc_byte_t count_reg; // Cycles since our own frame started.
  scc_byte_t count_next; // Next count.

  // Restart on every own frame start, then count while active.
  // Saturation keeps a long tenure from wrapping back under the limit.
  always_comb begin
    count_next = count_reg;
    if (frame_start) begin
      count_next = 8'h00;
    end else if (active && count_reg != `SCC_TENURE_MAX) begin
      count_next = count_reg + 8'h01;
    end
  end

  // Register the count.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  // Expiry is combinational so the stop request follows grant removal at once.
  assign expired = (count_reg >= limit);
  assign stop_req = active && expired && gnt_n;

  restart_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    frame_start |=> count_reg == 8'h00) else $error("Tenure count did not restart.");

  // The count may already be past the limit when the grant goes away.
  stop_on_gnt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (active && !frame_start && count_reg >= limit && gnt_n) |-> stop_req)
    else $error("Expired tenure not ended on grant loss.");
endmodule // scc_tenure_counter

//--- verilog/scc_config_header.sv
`timescale 1ns/1ps
`include "scc_params.svh"
// Contract
// - Category byte reads fixed communication code.
// - Programming interface zero, revision hardwired.
// - Writable tenure limit, restarts at frame.
// - Expired tenure ends when grant removed.
// - Writable line length used for line commands.
// - Self-test byte always reads zero.
// - Standard layout, multifunction bit from strap.
// - Base address upper bits are writable.
// - Base bits twelve to four read zero.
// - Base low type bits read zero.
// - Board maker id loaded, read-only here.
// - Access register write updates board maker id.
// - Board maker id cleared by global reset only.
module scc_config_header #(
  // Revision code; the value is arbitrary.
  parameter scc_pkg::scc_byte_t SILICON_REVISION = 8'h5a
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic global_reset_input_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire scc_pkg::scc_byte_t cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire scc_pkg::scc_word_t cfg_wdata,
  output scc_pkg::scc_word_t cfg_rdata,
  output logic cfg_ack,
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_board_id,
  input wire logic multifunction_strap,
  input wire logic initiator_frame_start,
  input wire logic initiator_active,
  input wire logic [3:0] initiator_cmd,
  input wire logic gnt_n,
  output logic tenure_expired,
  output logic initiator_stop_req,
  output scc_pkg::scc_byte_t line_length_setting,
  output scc_pkg::scc_byte_t burst_line_length,
  output scc_pkg::scc_word_t window_base
);
  import scc_pkg::*;

  // Everything but the board maker id also clears on the global reset.
  logic core_rst_n;
  assign core_rst_n = arst_n & global_reset_input_n;

  // Dword indices of the owned offsets, cut to the width of the index field.
  localparam logic [5:0] IDX_CLASS = 6'(`SCC_OFF_CLASS >> 2);
  localparam logic [5:0] IDX_TIMING = 6'(`SCC_OFF_TIMING >> 2);
  localparam logic [5:0] IDX_BASE = 6'(`SCC_OFF_BASE >> 2);
  localparam logic [5:0] IDX_BOARD = 6'(`SCC_OFF_BOARD >> 2);
  localparam logic [5:0] IDX_ACCESS = 6'(`SCC_OFF_SUBSYS_ACCESS >> 2);

  scc_sel_t sel; // Dword addressed by the current access.
  scc_byte_t tenure_limit_reg; // Host tenure limit, bus-clock cycles.
  scc_byte_t tenure_limit_next; // Next tenure limit.
  scc_byte_t line_reg; // Host cache line length.
  scc_byte_t line_next; // Next line length.
  logic [`SCC_BASE_W-1:0] base_reg; // Writable upper base address bits.
  logic [`SCC_BASE_W-1:0] base_next; // Next base bits.
  logic mf_reg; // Multifunction flag caught from the strap.
  logic mf_next; // Next multifunction flag.
  logic mf_taken_reg; // Strap has been caught since reset.
  scc_word_t rdata_next; // Read data for the next cycle.
  logic ack_next; // Access completes next cycle.
  logic [15:0] board_id_reg; // Board maker id, global reset only.
  logic [15:0] board_id_next; // Next board maker id.

  // Decode the dword index; byte lanes pick bytes inside it.
  always_comb begin
    case (cfg_addr[7:2])
      IDX_CLASS: sel = SCC_SEL_CLASS;
      IDX_TIMING: sel = SCC_SEL_TIMING;
      IDX_BASE: sel = SCC_SEL_BASE;
      IDX_BOARD: sel = SCC_SEL_BOARD;
      IDX_ACCESS: sel = SCC_SEL_ACCESS;
      default: sel = SCC_SEL_NONE;
    endcase
  end

  // Next values of the host-facing registers and the read port.
  // Writable fields and the multifunction flag appear here; other fixed fields have no storage,
  // so a write to them completes with an answer and alters nothing.
  always_comb begin
    tenure_limit_next = tenure_limit_reg;
    line_next = line_reg;
    base_next = base_reg;
    mf_next = mf_taken_reg ? mf_reg : multifunction_strap;
    ack_next = cfg_rd || cfg_wr;
    rdata_next = 32'h00000000;
    if (cfg_wr && sel == SCC_SEL_TIMING) begin
      // Bytes 2 and 3 of this dword are layout and self-test: ignored.
      if (cfg_be[1]) begin
        tenure_limit_next = cfg_wdata[15:8];
      end
      if (cfg_be[0]) begin
        line_next = cfg_wdata[7:0];
      end
    end
    if (cfg_wr && sel == SCC_SEL_BASE) begin
      // Lane 1 holds only bits 15..13 of the writable field.
      if (cfg_be[3]) begin
        base_next[18:11] = cfg_wdata[31:24];
      end
      if (cfg_be[2]) begin
        base_next[10:3] = cfg_wdata[23:16];
      end
      if (cfg_be[1]) begin
        base_next[2:0] = cfg_wdata[15:13];
      end
    end
    if (cfg_rd) begin
      case (sel)
        SCC_SEL_CLASS: begin
          rdata_next = {`SCC_CATEGORY, `SCC_SUBCLASS, `SCC_PGM_IF, SILICON_REVISION};
        end
        SCC_SEL_TIMING: begin
          rdata_next = {`SCC_SELF_TEST, mf_reg, `SCC_LAYOUT_STD, tenure_limit_reg, line_reg};
        end
        SCC_SEL_BASE: begin
          // Size, prefetch, type bits fixed zero
          rdata_next = {base_reg, 13'h0000};
        end
        SCC_SEL_BOARD: begin
          // The subsystem id above it is not part of this block.
          rdata_next = {16'h0000, board_id_reg};
        end
        default: begin
          // Unowned offsets and the write-only access port read zero.
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  // Register the core state. The strap is caught on the first clock after
  // reset release, never under the asynchronous reset itself.
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tenure_limit_reg <= `SCC_TIMING_RESET;
      line_reg <= `SCC_TIMING_RESET;
      base_reg <= `SCC_BASE_RESET;
      mf_reg <= 1'b0;
      mf_taken_reg <= 1'b0;
      cfg_rdata <= 32'h00000000;
      cfg_ack <= 1'b0;
    end else begin
      tenure_limit_reg <= tenure_limit_next;
      line_reg <= line_next;
      base_reg <= base_next;
      mf_reg <= mf_next;
      mf_taken_reg <= 1'b1;
      cfg_rdata <= rdata_next;
      cfg_ack <= ack_next;
    end
  end

  // Board maker id: the access port wins over a simultaneous EEPROM load,
  // since the host write is the later, deliberate value.
  always_comb begin
    board_id_next = board_id_reg;
    if (eeprom_load) begin
      board_id_next = eeprom_board_id;
    end
    if (cfg_wr && sel == SCC_SEL_ACCESS) begin
      if (cfg_be[0]) begin
        board_id_next[7:0] = cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        board_id_next[15:8] = cfg_wdata[15:8];
      end
    end
  end

  // Only the global reset clears this id, so a bus reset keeps it.
  always_ff @(posedge clk_sys or negedge global_reset_input_n) begin
    if (!global_reset_input_n) begin
      board_id_reg <= `SCC_BOARD_RESET;
    end else begin
      board_id_reg <= board_id_next;
    end
  end

  // Tenure counter for the block's own initiated transactions.
  scc_tenure_counter u_tenure (
    .clk_sys(clk_sys),
    .arst_n(core_rst_n),
    .frame_start(initiator_frame_start),
    .active(initiator_active),
    .gnt_n(gnt_n),
    .limit(tenure_limit_reg),
    .expired(tenure_expired),
    .stop_req(initiator_stop_req)
  );

  // Line length goes to the master only for the three line commands.
  always_comb begin
    case (initiator_cmd)
      `SCC_CMD_READ_MULT, `SCC_CMD_READ_LINE, `SCC_CMD_WRITE_INV: begin
        burst_line_length = line_reg;
      end
      default: begin
        burst_line_length = 8'h00;
      end
    endcase
  end

  assign line_length_setting = line_reg;
  assign window_base = {base_reg, 13'h0000};

  class_read_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_rd && sel == SCC_SEL_CLASS) |=> cfg_ack && cfg_rdata[31:8] == 24'h078000)
    else $error("Class dword read wrong.");

  self_test_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_rd && sel == SCC_SEL_TIMING) |=> cfg_rdata[31:24] == 8'h00 && cfg_rdata[22:16] == 7'h00)
    else $error("Self-test or layout field not zero.");

  layout_mf_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_rd && sel == SCC_SEL_TIMING) |=> cfg_rdata[23] == $past(mf_reg))
    else $error("Multifunction bit misreported.");

  tenure_write_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_wr && sel == SCC_SEL_TIMING && cfg_be[1])
    |=> tenure_limit_reg == $past(cfg_wdata[15:8]))
    else $error("Tenure limit not written.");

  line_use_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (initiator_cmd == `SCC_CMD_WRITE_INV) |-> burst_line_length == line_length_setting)
    else $error("Line length not applied.");

  base_write_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_wr && sel == SCC_SEL_BASE && cfg_be == 4'hf)
    |=> window_base == {$past(cfg_wdata[31:13]), 13'h0000})
    else $error("Base address not written.");

  base_low_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_rd && sel == SCC_SEL_BASE) |=> cfg_rdata[12:0] == 13'h0000)
    else $error("Base low bits not zero.");

  fixed_write_a: assert property (@(posedge clk_sys) disable iff (!core_rst_n)
    (cfg_wr && (sel == SCC_SEL_CLASS || sel == SCC_SEL_BOARD) && !eeprom_load)
    |=> cfg_ack && $stable(board_id_reg) && $stable(base_reg) && $stable(line_reg))
    else $error("Write to fixed field changed state.");

  board_update_a: assert property (@(posedge clk_sys) disable iff (!global_reset_input_n)
    (cfg_wr && sel == SCC_SEL_ACCESS && cfg_be[1:0] == 2'h3) |=> board_id_reg == $past(cfg_wdata[15:0]))
    else $error("Board maker id not updated.");

  board_keep_a: assert property (@(posedge clk_sys) disable iff (!global_reset_input_n)
    (!arst_n && !eeprom_load) |=> $stable(board_id_reg))
    else $error("Bus reset disturbed board maker id.");
endmodule // scc_config_header

//--- tb/scc_host_arbiter.sv
`timescale 1ns/1ps
// Host-side arbiter: grants the bus to the block while it asks for it and no revoke is raised.
module scc_host_arbiter (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic want,
  input wire logic revoke,
  output logic gnt_n
);
  logic gnt_n_next;
  // The grant drops one clock after a revoke, never in the same cycle.
  always_comb begin
    gnt_n_next = !(want && !revoke);
  end
  // The grant is registered because a real arbiter answers on clock edges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gnt_n <= 1'b1;
    end else begin
      gnt_n <= gnt_n_next;
    end
  end
endmodule // scc_host_arbiter

//--- tb/tb.sv
`timescale 1ns/1ps
`include "scc_params.svh"
module tb;
  import scc_pkg::*;
  // Revision code; the value is arbitrary.
  localparam scc_byte_t REV = 8'h3c;
  logic clk_sys, arst_n, glob_n, rd, wr, eload, strap, fstart, act, want, revoke;
  logic gnt_n, expired, stop_req, ack;
  logic [3:0] be, cmd;
  logic [15:0] eid;
  scc_byte_t addr, line_q, burst_q;
  scc_word_t wdata, rdata, base_q, rv, rs, v;
  int fails = 0;
  int comparisons = 0;
  scc_config_header #(.SILICON_REVISION(REV)) i_scc_config_header (.clk_sys(clk_sys),
    .arst_n(arst_n), .global_reset_input_n(glob_n), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_ack(ack), .eeprom_load(eload),
    .eeprom_board_id(eid), .multifunction_strap(strap), .initiator_frame_start(fstart),
    .initiator_active(act), .initiator_cmd(cmd), .gnt_n(gnt_n), .tenure_expired(expired),
    .initiator_stop_req(stop_req), .line_length_setting(line_q), .burst_line_length(burst_q),
    .window_base(base_q));
  scc_host_arbiter i_scc_host_arbiter (.clk_sys(clk_sys), .arst_n(arst_n), .want(want),
    .revoke(revoke), .gnt_n(gnt_n));
  // Xorshift keeps the random stream identical from run to run.
  function automatic scc_word_t xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Expected dword at 0Ch for a given low half.
  function automatic scc_word_t timing(input logic [15:0] lo);
    return {8'h00, strap, 7'h00, lo};
  endfunction
  // Compares one value and counts the outcome.
  task automatic chk(input scc_word_t seen, input scc_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One configuration access; the answer is sampled once it has settled.
  task automatic acc(input logic w, input scc_byte_t a, input logic [3:0] b, input scc_word_t d);
    @(posedge clk_sys);
    rd <= !w;
    wr <= w;
    addr <= a;
    be <= b;
    wdata <= d;
    @(posedge clk_sys);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    rv = rdata;
    chk({31'h0, ack}, 32'h1);
  endtask
  // Reads a dword and compares it.
  task automatic rdchk(input scc_byte_t a, input scc_word_t exp);
    acc(1'b0, a, 4'h0, 32'h0);
    chk(rv, exp);
  endtask
  // Pulses the chosen resets for one clock.
  task automatic pulse_reset(input logic both);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    glob_n <= !both;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    glob_n <= 1'b1;
  endtask
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // The clock: 40 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // The whole run needs well under this span; a hang ends here.
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  initial begin
    {arst_n, glob_n, rd, wr, eload, fstart, act, want, revoke} = '0;
    {be, cmd, eid, addr, wdata} = '0;
    strap = 1'b1;
    rs = 32'hbe8f2e99;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    glob_n <= 1'b1;
    rdchk(`SCC_OFF_CLASS, {8'h07, 8'h80, 8'h00, REV});
    rdchk(`SCC_OFF_TIMING, timing(16'h0));
    rdchk(`SCC_OFF_BASE, 32'h0);
    rdchk(`SCC_OFF_BOARD, 32'h0);
    // Fixed fields take writes without any trace.
    acc(1'b1, `SCC_OFF_CLASS, 4'hf, xs());
    rdchk(`SCC_OFF_CLASS, {8'h07, 8'h80, 8'h00, REV});
    acc(1'b1, `SCC_OFF_LAYOUT, 4'hc, 32'hffffffff);
    rdchk(`SCC_OFF_TIMING, timing(16'h0));
    // Random writes to the writable fields, including the all-ones corner.
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hffffffff : xs();
      acc(1'b1, `SCC_OFF_TIMING, 4'h3, v);
      rdchk(`SCC_OFF_TIMING, timing(v[15:0]));
      chk({24'h0, line_q}, {24'h0, v[7:0]});
      acc(1'b1, `SCC_OFF_BASE, 4'hf, v);
      rdchk(`SCC_OFF_BASE, {v[31:13], 13'h0});
      chk(base_q, {v[31:13], 13'h0});
    end
    // Only the three line commands see the line length.
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_sys);
      cmd <= c[3:0];
      @(posedge clk_sys);
      #1;
      chk({24'h0, burst_q}, (c == 12 || c == 14 || c == 15) ? {24'h0, v[7:0]} : 32'h0);
    end
    // Board id: loaded, read-only at its offset, updated through 50h.
    @(posedge clk_sys);
    v = xs();
    eid <= v[15:0];
    eload <= 1'b1;
    @(posedge clk_sys);
    eload <= 1'b0;
    rdchk(`SCC_OFF_BOARD, {16'h0, eid});
    acc(1'b1, `SCC_OFF_BOARD, 4'hf, ~{16'h0, eid});
    rdchk(`SCC_OFF_BOARD, {16'h0, eid});
    v = xs();
    acc(1'b1, `SCC_OFF_SUBSYS_ACCESS, 4'h3, v);
    rdchk(`SCC_OFF_BOARD, {16'h0, v[15:0]});
    // A bus reset clears the settings but keeps the board id.
    pulse_reset(1'b0);
    rdchk(`SCC_OFF_BOARD, {16'h0, v[15:0]});
    rdchk(`SCC_OFF_TIMING, timing(16'h0));
    pulse_reset(1'b1);
    // The strap is low at the first edge after release and high later on.
    strap <= 1'b0;
    rdchk(`SCC_OFF_BOARD, 32'h0);
    @(posedge clk_sys);
    strap <= 1'b1;
    rdchk(`SCC_OFF_TIMING, 32'h00000000);
    // Tenure limit of two cycles, then the grant is taken away.
    acc(1'b1, `SCC_OFF_TIMING, 4'h3, 32'h00000210);
    @(posedge clk_sys);
    want <= 1'b1;
    repeat (3) @(posedge clk_sys);
    fstart <= 1'b1;
    @(posedge clk_sys);
    fstart <= 1'b0;
    act <= 1'b1;
    #1;
    chk({31'h0, expired}, 32'h0);
    @(posedge clk_sys);
    #1;
    chk({31'h0, expired}, 32'h0);
    @(posedge clk_sys);
    #1;
    chk({30'h0, expired, stop_req}, 32'h2);
    @(posedge clk_sys);
    revoke <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({31'h0, stop_req}, 32'h1);
    // A new own frame restarts the long count, so expiry clears again.
    @(posedge clk_sys);
    fstart <= 1'b1;
    @(posedge clk_sys);
    fstart <= 1'b0;
    #1;
    chk({30'h0, expired, stop_req}, 32'h0);
    print_verdict();
  end
endmodule // tb
